// file: oicr_regs.sv
// Operation control and second I/O configuration registers
`include "oicr_defines.svh"
module oicr_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic soft_rst,
	input wire oicr_pkg::oicr_req_s req,
	input wire logic field_on_cmd,
	input wire logic tx_finished,
	input wire logic active_peer_mode,
	input wire logic channel_choice,
	input wire logic spi_mode,
	input wire logic chip_select_line,
	input wire logic data_out_driven,
	output logic rd_valid,
	output oicr_pkg::oicr_byte_t rd_data,
	output logic osc_regulator_on,
	output oicr_pkg::oicr_rx_s rx_ctl,
	output logic rx_manual_channel,
	output logic tx_on,
	output logic wakeup_mode_on,
	output oicr_pkg::oicr_fd_e field_detector_mode,
	output logic low_power_initial,
	output logic tuning_dac_run,
	output logic tuning_hold_fixed,
	output logic data_out_pulldown,
	output logic pad_drive_high,
	output logic low_supply_select,
	output logic digital_regulator_off,
	output logic modulation_regulator_reference,
	output logic active_sink_on
);
	import oicr_pkg::*;

	// ==========================================
	// Storage
	oicr_byte_t io_configuration_two;
	oicr_byte_t operation_control;
	logic ready_seen;
	logic cs_meta;
	logic cs_sync;

	// ==========================================
	// Decode
	wire logic hit_io = req.addr == `OICR_OFS_IO_CONFIGURATION_TWO;
	wire logic hit_op = req.addr == `OICR_OFS_OPERATION_CONTROL;
	wire logic wr_io = req.wr && hit_io;
	wire logic wr_op = req.wr && hit_op;
	wire oicr_byte_t next_rd_data = hit_io ? io_configuration_two :
		hit_op ? operation_control : 8'h00;

	// Hardware set wins over host write and self clear
	wire logic tx_self_clear = tx_finished && active_peer_mode;
	wire logic next_tx_bit = field_on_cmd ? 1'b1 :
		tx_self_clear ? 1'b0 :
		wr_op ? req.wdata[`OICR_OP_TX_ON] :
		operation_control[`OICR_OP_TX_ON];

	oicr_byte_t next_operation_control;
	always_comb begin
		next_operation_control = wr_op ? req.wdata : operation_control;
		next_operation_control[`OICR_OP_TX_ON] = next_tx_bit;
	end

	wire oicr_byte_t op = operation_control;
	wire oicr_byte_t io = io_configuration_two;
	wire logic ready = op[`OICR_OP_READY];
	wire logic single_ch = op[`OICR_OP_SINGLE_CH];
	wire logic rx_enable = op[`OICR_OP_RX_ON];
	wire logic next_am = rx_enable && (!single_ch || !channel_choice);
	wire logic next_pm = rx_enable && (!single_ch || channel_choice);
	wire logic next_auto = rx_enable && !single_ch &&
		!op[`OICR_OP_MANUAL_PICK];
	wire logic next_low_power = op[1:0] != 2'b00 && op[7:2] == 6'h00;
	wire logic tuning_en = io[`OICR_IO_TUNING_EN];
	wire logic next_pd = spi_mode &&
		((!cs_sync && !data_out_driven && io[`OICR_IO_PD_SELECTED]) ||
		(cs_sync && io[`OICR_IO_PD_DESELECTED]));

	// ==========================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			operation_control <= `OICR_RST_OPERATION_CONTROL;
		end else begin
			operation_control <= next_operation_control;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || soft_rst) begin
			io_configuration_two <= `OICR_RST_IO_CONFIGURATION_TWO;
		end else if (wr_io) begin
			io_configuration_two <= req.wdata;
		end
	end

	// Remembers ready mode since power-up
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ready_seen <= 1'b0;
		end else if (ready) begin
			ready_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
		end else begin
			cs_meta <= chip_select_line;
			cs_sync <= cs_meta;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			rd_valid <= req.rd;
			rd_data <= req.rd ? next_rd_data : 8'h00;
		end
	end

	// ==========================================
	// Control outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_regulator_on <= 1'b0;
			rx_ctl <= '0;
			rx_manual_channel <= 1'b0;
			tx_on <= 1'b0;
			wakeup_mode_on <= 1'b0;
			field_detector_mode <= OICR_FD_OFF;
			low_power_initial <= 1'b0;
		end else begin
			osc_regulator_on <= ready;
			rx_ctl <= '{rx_enable, next_am, next_pm, next_auto};
			rx_manual_channel <= channel_choice;
			tx_on <= op[`OICR_OP_TX_ON];
			wakeup_mode_on <= op[`OICR_OP_WAKEUP];
			field_detector_mode <= oicr_fd_e'(op[1:0]);
			low_power_initial <= next_low_power;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tuning_dac_run <= 1'b0;
			tuning_hold_fixed <= 1'b0;
			data_out_pulldown <= 1'b0;
			pad_drive_high <= 1'b0;
			low_supply_select <= 1'b0;
			digital_regulator_off <= 1'b0;
			modulation_regulator_reference <= 1'b0;
			active_sink_on <= 1'b0;
		end else begin
			tuning_dac_run <= tuning_en && ready;
			tuning_hold_fixed <= tuning_en && !ready && ready_seen;
			data_out_pulldown <= next_pd;
			pad_drive_high <= io[`OICR_IO_PAD_DRIVE];
			low_supply_select <= io[`OICR_IO_LOW_SUPPLY];
			digital_regulator_off <= io[`OICR_IO_REG_OFF];
			modulation_regulator_reference <= io[`OICR_IO_MOD_REG_REF];
			active_sink_on <= io[`OICR_IO_ACTIVE_SINK];
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_field_on;
		field_on_cmd;
	endsequence

	sequence s_tx_seen;
		##1 operation_control[`OICR_OP_TX_ON] ##1 tx_on;
	endsequence

	a_tx_field_set: assert property (s_field_on |-> s_tx_seen)
		else $error("transmit-on not set by field-on");

	a_tx_self_clear: assert property (
		tx_finished && active_peer_mode && !field_on_cmd
		|=> !operation_control[`OICR_OP_TX_ON] ##1 !tx_on)
		else $error("transmit-on not cleared after transmit");

	a_tx_host_write: assert property (
		wr_op && !field_on_cmd && !tx_self_clear |=>
		operation_control[`OICR_OP_TX_ON] ==
		$past(req.wdata[`OICR_OP_TX_ON]))
		else $error("transmit-on does not take host write");

	a_ready_follow: assert property (
		wr_op |-> ##2 osc_regulator_on ==
		$past(req.wdata[`OICR_OP_READY], 2))
		else $error("ready output does not follow write");

	a_rx_gate: assert property (
		!rx_ctl.rx_on |-> !rx_ctl.am_on && !rx_ctl.pm_on)
		else $error("receive channel on with receive off");

	a_single_channel: assert property (
		rx_ctl.rx_on && $past(single_ch) |-> rx_ctl.am_on != rx_ctl.pm_on &&
		!rx_ctl.auto_sel)
		else $error("single channel mode wrong");

	a_auto_pick: assert property (
		$past(rx_enable && !single_ch) |->
		rx_ctl.auto_sel == !$past(op[`OICR_OP_MANUAL_PICK]))
		else $error("channel selection method wrong");

	a_manual_channel: assert property (
		!$past(rst) |-> rx_manual_channel == $past(channel_choice))
		else $error("channel choice copy wrong");

	a_wakeup_mode: assert property (
		wakeup_mode_on == $past(op[`OICR_OP_WAKEUP]))
		else $error("wake-up mode does not follow bit");

	a_fd_mode: assert property (
		field_detector_mode == $past(op[1:0]))
		else $error("detector mode does not follow field");

	a_low_power: assert property (
		wr_op && !field_on_cmd && !tx_self_clear && req.wdata == 8'h01
		|-> ##2 low_power_initial)
		else $error("low power initial mode not entered");

	a_tuning_run: assert property (
		tuning_dac_run |-> $past(tuning_en && ready))
		else $error("tuning converters run without both bits");

	a_tuning_dac_on: assert property (
		tuning_en && ready |=> tuning_dac_run)
		else $error("tuning converters idle with both bits");

	a_tuning_hold: assert property (
		tuning_hold_fixed |-> !tuning_dac_run && $past(ready_seen))
		else $error("tuning hold without earlier ready");

	a_tuning_hold_on: assert property (
		tuning_en && !ready && ready_seen |=> tuning_hold_fixed)
		else $error("tuning hold missing after ready");

	a_cs_sync_delay: assert property (
		!$past(rst) && !$past(rst, 2)
		|-> cs_sync == $past(chip_select_line, 2))
		else $error("chip select synchroniser delay wrong");

	a_pd_select: assert property (
		data_out_pulldown |-> $past(spi_mode))
		else $error("pull-down outside SPI mode");

	a_pd_deselected: assert property (
		spi_mode && cs_sync && io[`OICR_IO_PD_DESELECTED]
		|=> data_out_pulldown)
		else $error("pull-down missing while deselected");

	a_pd_selected: assert property (
		spi_mode && !cs_sync && !data_out_driven &&
		io[`OICR_IO_PD_SELECTED] |=> data_out_pulldown)
		else $error("pull-down missing while selected");

	a_pad_drive: assert property (
		wr_io && !soft_rst |-> ##2 pad_drive_high ==
		$past(req.wdata[`OICR_IO_PAD_DRIVE], 2))
		else $error("pad drive does not follow bit");

	a_op_keep: assert property (
		soft_rst && !wr_op && !field_on_cmd && !tx_self_clear
		|=> $stable(operation_control))
		else $error("operation register lost on soft reset");

	a_io_soft_clear: assert property (
		soft_rst |=>
		io_configuration_two == `OICR_RST_IO_CONFIGURATION_TWO)
		else $error("second I/O register kept on soft reset");

	a_read_back: assert property (
		req.rd && hit_op && !req.wr
		|=> rd_valid && rd_data == $past(operation_control))
		else $error("read data mismatch");

	a_io_read_back: assert property (
		req.rd && hit_io && !req.wr
		|=> rd_valid && rd_data == $past(io_configuration_two))
		else $error("second I/O read data mismatch");

	a_unmapped_read: assert property (
		req.rd && !hit_io && !hit_op |=> rd_valid && rd_data == 8'h00)
		else $error("unmapped read not zero");
endmodule

// file: oicr_defines.svh
// Offsets, field positions and reset values of the control register pair
`ifndef OICR_DEFINES_SVH
`define OICR_DEFINES_SVH
// ==========================================
// Register offsets
`define OICR_OFS_IO_CONFIGURATION_TWO 8'h01
`define OICR_OFS_OPERATION_CONTROL 8'h02
// ==========================================
// Reset values
`define OICR_RST_IO_CONFIGURATION_TWO 8'h00
`define OICR_RST_OPERATION_CONTROL 8'h00
// ==========================================
// Second I/O register fields
`define OICR_IO_LOW_SUPPLY 7
`define OICR_IO_REG_OFF 6
`define OICR_IO_TUNING_EN 5
`define OICR_IO_PD_SELECTED 4
`define OICR_IO_PD_DESELECTED 3
`define OICR_IO_PAD_DRIVE 2
`define OICR_IO_MOD_REG_REF 1
`define OICR_IO_ACTIVE_SINK 0
// ==========================================
// Operation register fields
`define OICR_OP_READY 7
`define OICR_OP_RX_ON 6
`define OICR_OP_SINGLE_CH 5
`define OICR_OP_MANUAL_PICK 4
`define OICR_OP_TX_ON 3
`define OICR_OP_WAKEUP 2
`define OICR_OP_FD_HI 1
`define OICR_OP_FD_LO 0
`endif

// file: oicr_pkg.sv
// Types shared by the control register pair and its users
package oicr_pkg;
	typedef logic [7:0] oicr_byte_t;

	// Register port request from the serial host interface
	typedef struct packed {
		logic wr;
		logic rd;
		oicr_byte_t addr;
		oicr_byte_t wdata;
	} oicr_req_s;

	// Field detector modes
	typedef enum logic [1:0] {
		OICR_FD_OFF,
		OICR_FD_COLLISION,
		OICR_FD_PEER,
		OICR_FD_AUTO
	} oicr_fd_e;

	// Receive path steering
	typedef struct packed {
		logic rx_on;
		logic am_on;
		logic pm_on;
		logic auto_sel;
	} oicr_rx_s;
endpackage

// file: oicr_host_model.sv
// Host model driving the register port of the control pair
module oicr_host_model (
	input wire logic clk_sys,
	output oicr_pkg::oicr_req_s req,
	input wire logic rd_valid,
	input wire oicr_pkg::oicr_byte_t rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	import oicr_pkg::*;
	initial req = '0;
	// ==========================================
	// Register cycles, idle address inverted, idle write data inverted after a write
	task automatic wr(input oicr_byte_t a, input oicr_byte_t d);
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input oicr_byte_t a, output logic v,
		output oicr_byte_t d);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: req.wdata};
		#1;
		v = rd_valid;
		d = rd_data;
	endtask
	// ==========================================
	// Setup before field-on commands
	task automatic prep(input logic peer);
		wr(8'h01, 8'h04);
		wr(8'h02, peer ? 8'h83 : 8'h81);
	endtask
endmodule

// file: tb_oicr_regs.sv
// Self-checking testbench for the control register pair
module tb_oicr_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import oicr_pkg::*;
	logic clk_sys = 0;
	logic rst = 1;
	logic soft_rst = 0;
	logic field_on_cmd = 0;
	logic tx_finished = 0;
	logic active_peer_mode = 0;
	logic channel_choice = 0;
	logic spi_mode = 0;
	logic chip_select_line = 1;
	logic data_out_driven = 0;
	oicr_req_s req;
	logic rd_valid, osc_regulator_on, rx_manual_channel, tx_on;
	logic wakeup_mode_on, low_power_initial, tuning_dac_run;
	logic tuning_hold_fixed, data_out_pulldown, pad_drive_high, v;
	logic low_supply_select, digital_regulator_off, active_sink_on;
	logic modulation_regulator_reference;
	oicr_byte_t rd_data, d, op, io;
	oicr_rx_s rx_ctl;
	oicr_fd_e field_detector_mode;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int i;
	always #50 clk_sys = ~clk_sys;
	oicr_host_model HOST (.clk_sys(clk_sys), .req(req),
		.rd_valid(rd_valid), .rd_data(rd_data));
	oicr_regs DUT (.clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst),
		.req(req), .field_on_cmd(field_on_cmd), .tx_finished(tx_finished),
		.active_peer_mode(active_peer_mode),
		.channel_choice(channel_choice), .spi_mode(spi_mode),
		.chip_select_line(chip_select_line),
		.data_out_driven(data_out_driven), .rd_valid(rd_valid),
		.rd_data(rd_data), .osc_regulator_on(osc_regulator_on),
		.rx_ctl(rx_ctl), .rx_manual_channel(rx_manual_channel),
		.tx_on(tx_on), .wakeup_mode_on(wakeup_mode_on),
		.field_detector_mode(field_detector_mode),
		.low_power_initial(low_power_initial),
		.tuning_dac_run(tuning_dac_run),
		.tuning_hold_fixed(tuning_hold_fixed),
		.data_out_pulldown(data_out_pulldown),
		.pad_drive_high(pad_drive_high),
		.low_supply_select(low_supply_select),
		.digital_regulator_off(digital_regulator_off),
		.modulation_regulator_reference(modulation_regulator_reference),
		.active_sink_on(active_sink_on));
	// ==========================================
	// Compare and helper tasks
	task automatic chk8(input oicr_byte_t g, input oicr_byte_t e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic settle();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rdchk(input oicr_byte_t a, input oicr_byte_t e);
		HOST.rd(a, v, d);
		chk1(v, 1'b1);
		chk8(d, e);
	endtask
	task automatic pulse(input logic f, input logic t);
		@(posedge clk_sys);
		field_on_cmd <= f;
		tx_finished <= t;
		@(posedge clk_sys);
		field_on_cmd <= 1'b0;
		tx_finished <= 1'b0;
		settle();
	endtask
	function automatic logic lp(input oicr_byte_t o);
		return o[1:0] != 2'b00 && o[7:2] == 6'h00;
	endfunction
	task automatic chk_op(input oicr_byte_t o);
		chk1(osc_regulator_on, o[7]);
		chk1(rx_ctl.rx_on, o[6]);
		if (o[6]) begin
			chk1(rx_ctl.am_on, !o[5] || !channel_choice);
			chk1(rx_ctl.pm_on, !o[5] || channel_choice);
			chk1(rx_ctl.auto_sel, !o[5] && !o[4]);
		end
		chk1(rx_manual_channel, channel_choice);
		chk1(tx_on, o[3]);
		chk1(wakeup_mode_on, o[2]);
		chk8({6'h00, field_detector_mode}, {6'h00, o[1:0]});
		chk1(low_power_initial, lp(o));
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(53));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h00);
		rdchk(8'h05, 8'h00);
		$display("reset done");
		HOST.wr(8'h01, 8'h20);
		settle();
		chk1(tuning_hold_fixed, 1'b0);
		HOST.wr(8'h02, 8'h80);
		settle();
		chk1(tuning_dac_run, 1'b1);
		HOST.wr(8'h02, 8'h00);
		settle();
		chk1(tuning_hold_fixed, 1'b1);
		chk1(tuning_dac_run, 1'b0);
		$display("tuning done");
		for (i = 0; i < 24; i++) begin
			op = (i < 4) ? i[7:0] : 8'($urandom);
			io = 8'($urandom);
			@(posedge clk_sys);
			channel_choice <= io[7];
			HOST.wr(8'h01, io);
			HOST.wr(8'h02, op);
			settle();
			chk_op(op);
			chk1(pad_drive_high, io[2]);
			chk1(tuning_dac_run, io[5] & op[7]);
			chk1(low_supply_select, io[7]);
			chk1(digital_regulator_off, io[6]);
			chk1(modulation_regulator_reference, io[1]);
			chk1(active_sink_on, io[0]);
			rdchk(8'h01, io);
			rdchk(8'h02, op);
		end
		$display("fields done");
		HOST.prep(1'b0);
		pulse(1'b1, 1'b0);
		chk1(tx_on, 1'b1);
		pulse(1'b0, 1'b1);
		chk1(tx_on, 1'b1);
		rdchk(8'h02, 8'h89);
		@(posedge clk_sys);
		active_peer_mode <= 1'b1;
		HOST.prep(1'b1);
		pulse(1'b1, 1'b0);
		rdchk(8'h02, 8'h8b);
		pulse(1'b0, 1'b1);
		chk1(tx_on, 1'b0);
		rdchk(8'h02, 8'h83);
		$display("transmit done");
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			spi_mode <= i[3];
			chip_select_line <= i[2];
			data_out_driven <= i[1];
			HOST.wr(8'h01, i[0] ? 8'h10 : 8'h08);
			repeat (4) @(posedge clk_sys);
			#1;
			chk1(data_out_pulldown,
				i[3] & (i[0] ? (!i[2] & !i[1]) : i[2]));
		end
		$display("pulldown done");
		HOST.wr(8'h01, 8'h04);
		HOST.wr(8'h02, 8'h85);
		@(posedge clk_sys);
		soft_rst <= 1'b1;
		@(posedge clk_sys);
		soft_rst <= 1'b0;
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h85);
		chk1(pad_drive_high, 1'b0);
		$display("soft reset done");
		summarize();
	end
endmodule
